/* testbench.sv */
// Self-checking bench for the word store block with its memory partner.
// Assumes default options: translation present, unaligned stores fault.
`timescale 1ns/10ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin n_errors++; \
  $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end

module testbench;
  localparam logic [31:0] OFS = 32'h1000_0000;
  logic i_clk_sys = 1'b0;
  logic i_reset_n = 1'b0;
  logic i_req_valid = 1'b0;
  wse_pkg::wse_req_type i_req = '0;
  logic [1:0] cur_ring = 2'h0, sring = 2'h0, dly = 2'h0;
  logic pending = 1'b0, fx = 1'b0, fm = 1'b0, rwr = 1'b0, rrd = 1'b0;
  logic [3:0] ra = 4'h0;
  logic [31:0] rw = 32'h0, seed = 32'h5cd42069;
  logic xv, xd, xf, mv, md, me, done, exc, irq, ready;
  logic [31:0] xva, xpa, eva, rdata, cap_va;
  logic [1:0] xring, cap_ring;
  logic [5:0] cause;
  wse_pkg::wse_mem_type mem, cap_mem;
  logic early = 1'b0, got_done = 1'b0, got_exc = 1'b0;
  int n_errors = 0, compares = 0;

  always #4 i_clk_sys = ~i_clk_sys;

  wse_core u_wse_core (.i_clk_sys, .i_reset_n, .i_req_valid, .i_req, .i_current_privilege_ring(cur_ring),
    .i_saved_ring_level(sring), .o_req_ready(ready), .i_mem_ops_pending(pending), .o_xlt_valid(xv),
    .o_xlt_vaddr(xva), .o_xlt_ring(xring), .i_xlt_done(xd), .i_xlt_paddr(xpa), .i_xlt_fault(xf),
    .o_mem_valid(mv), .o_mem(mem), .i_mem_done(md), .i_mem_error(me), .o_done(done), .o_exc(exc),
    .o_exc_cause(cause), .o_exc_vaddr(eva), .i_reg_addr(ra), .i_reg_wdata(rw), .i_reg_wr(rwr),
    .i_reg_rd(rrd), .o_reg_rdata(rdata), .o_irq(irq));

  wse_mem_model #(.XLT_OFS(OFS)) u_wse_mem_model (.i_clk_sys, .i_delay(dly), .i_fault_xlt(fx),
    .i_fault_mem(fm), .i_xlt_valid(xv), .i_xlt_vaddr(xva), .o_xlt_done(xd), .o_xlt_paddr(xpa),
    .o_xlt_fault(xf), .i_mem_valid(mv), .o_mem_done(md), .o_mem_error(me));

  // Monitor: pre-edge values, so no race with the design's registers
  always @(posedge i_clk_sys) begin
    if (xv) begin
      cap_va <= xva;
      cap_ring <= xring;
    end
    if (mv && md) cap_mem <= mem;
    if (mv && pending) early <= 1'b1;
    if (done) begin
      got_done <= 1'b1;
      got_exc <= exc;
    end
  end

  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function logic [31:0] exp_va(wse_pkg::wse_op_type op, logic [31:0] b, logic [7:0] im);
    case (op)
      wse_pkg::WSE_OP_WINDOW: return b + {26'h3FFFFFF, im[3:0], 2'h0};
      wse_pkg::WSE_OP_NARROW: return b + {26'h0, im[3:0], 2'h0};
      default: return b + {22'h0, im, 2'h0};
    endcase
  endfunction

  // Priority: privilege, alignment, translation, then memory answer
  function logic [6:0] exp_exc(wse_pkg::wse_op_type op, logic [31:0] va, logic [1:0] cr, logic f1, f2);
    if (op == wse_pkg::WSE_OP_WINDOW && cr != 2'h0) return {1'b1, wse_pkg::WSE_CAUSE_PRIV};
    if (va[1:0] != 2'h0) return {1'b1, wse_pkg::WSE_CAUSE_UNALIGNED};
    if (f1) return {1'b1, wse_pkg::WSE_CAUSE_STORE_PROHIBITED};
    if (f2) return {1'b1, wse_pkg::WSE_CAUSE_STORE_ERROR};
    return 7'h00;
  endfunction

  task automatic store(input wse_pkg::wse_op_type op, input logic [31:0] b, d, input logic [7:0] im,
    input logic [1:0] cr, sr, dl, input logic f1, f2, input int pend);
    logic [6:0] ec;
    logic [31:0] va;
    int i;
    va = exp_va(op, b, im);
    ec = exp_exc(op, va, cr, f1, f2);
    @(posedge i_clk_sys);
    i_req_valid <= 1'b1;
    i_req <= '{op, b, d, im};
    {cur_ring, sring, dly, fx, fm} <= {cr, sr, dl, f1, f2};
    pending <= (pend > 0);
    {early, got_done, got_exc} <= 3'h0;
    @(posedge i_clk_sys);
    i_req_valid <= 1'b0;
    repeat (pend) @(posedge i_clk_sys);
    pending <= 1'b0;
    for (i = 0; i < 60 && !got_done; i++) @(posedge i_clk_sys);
    repeat (2) @(posedge i_clk_sys);
    `CHK("done", 1'b1, got_done)
    `CHK("exc", ec[6], got_exc)
    if (ec[6]) begin
      `CHK("cause", ec[5:0], cause)
      if (ec[5:0] != wse_pkg::WSE_CAUSE_PRIV) `CHK("exc vaddr", va, eva)
    end else begin
      `CHK("vaddr", va, cap_va)
      if (op == wse_pkg::WSE_OP_WINDOW) `CHK("ring", sr, cap_ring)
      `CHK("paddr", (va + OFS) & ~32'h3, cap_mem.paddr)
      `CHK("data", d, cap_mem.data)
      `CHK("mem ring", (op == wse_pkg::WSE_OP_WINDOW) ? sr : cr, cap_mem.ring)
      `CHK("iram", op == wse_pkg::WSE_OP_WIDE || op == wse_pkg::WSE_OP_NARROW, cap_mem.to_iram_ok)
      `CHK("order", 1'b0, early)
    end
    `CHK("ready", 1'b1, ready)
    $display("test store op %0d ends", op);
  endtask

  // One register access; read data are looked at in the cycle after the strobe
  task automatic reg_io(input logic wr, input logic [3:0] a, input logic [31:0] wd, ex, input string nm);
    @(posedge i_clk_sys);
    {ra, rw, rwr, rrd} <= {a, wd, wr, !wr};
    @(posedge i_clk_sys);
    {rwr, rrd} <= 2'h0;
    #1;
    if (!wr) `CHK(nm, ex, rdata)
  endtask

  task close_out;
    $display("comparisons %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  initial begin
    logic [31:0] r;
    repeat (6) @(posedge i_clk_sys);
    i_reset_n <= 1'b1;
    // Corners: offset limits, saved ring, privilege, release drain, faults
    store(wse_pkg::WSE_OP_WIDE, 32'h2000_0000, 32'hA5A5_5A5A, 8'hFF, 2'h0, 2'h0, 2'h0, 1'b0, 1'b0, 0);
    store(wse_pkg::WSE_OP_WINDOW, 32'h2000_0100, 32'h1234_5678, 8'h00, 2'h0, 2'h3, 2'h1, 1'b0, 1'b0, 0);
    store(wse_pkg::WSE_OP_WINDOW, 32'h0000_0000, 32'h0BAD_F00D, 8'h0F, 2'h0, 2'h2, 2'h0, 1'b0, 1'b0, 0);
    store(wse_pkg::WSE_OP_WINDOW, 32'h2000_0100, 32'h1111_2222, 8'h05, 2'h2, 2'h0, 2'h0, 1'b0, 1'b0, 0);
    store(wse_pkg::WSE_OP_NARROW, 32'h3000_0000, 32'hCAFE_0001, 8'hFF, 2'h1, 2'h0, 2'h2, 1'b0, 1'b0, 0);
    store(wse_pkg::WSE_OP_RELEASE, 32'h4000_0000, 32'hFEED_0002, 8'h80, 2'h0, 2'h0, 2'h0, 1'b0, 1'b0, 7);
    store(wse_pkg::WSE_OP_WIDE, 32'h5000_0002, 32'h0, 8'h01, 2'h0, 2'h0, 2'h0, 1'b0, 1'b0, 0);
    store(wse_pkg::WSE_OP_RELEASE, 32'h6000_0000, 32'h3, 8'h04, 2'h0, 2'h0, 2'h3, 1'b1, 1'b0, 0);
    store(wse_pkg::WSE_OP_WIDE, 32'h7000_0000, 32'h4, 8'h10, 2'h0, 2'h0, 2'h3, 1'b0, 1'b1, 0);
    // Sticky status, mask, interrupt, last fault, unmapped place
    reg_io(1'b0, 4'h0, 32'h0, 32'h3, "status");
    reg_io(1'b0, 4'h8, 32'h0, {26'h0, wse_pkg::WSE_CAUSE_STORE_ERROR}, "last cause");
    reg_io(1'b0, 4'hC, 32'h0, 32'h7000_0040, "last vaddr");
    reg_io(1'b1, 4'h4, 32'h2, 32'h0, "");
    `CHK("irq on", 1'b1, irq)
    reg_io(1'b1, 4'h0, 32'h2, 32'h0, "");
    `CHK("irq off", 1'b0, irq)
    reg_io(1'b0, 4'h0, 32'h0, 32'h1, "status clr");
    reg_io(1'b0, 4'h4, 32'h0, 32'h2, "mask");
    reg_io(1'b0, 4'h1, 32'h0, 32'h0, "unmapped");
    $display("test registers ends");
    // Random stores of every kind
    repeat (80) begin
      r = rnd();
      store(wse_pkg::wse_op_type'(3'(1 + r[1:0])), rnd() & {30'h3FFFFFFF, r[4:2] == 3'h0, 1'b0}, rnd(),
        r[15:8], (r[7:5] == 3'h0) ? r[17:16] : 2'h0, r[19:18], r[21:20], r[24:22] == 3'h0,
        r[27:25] == 3'h0, (r[1:0] == 2'h3) ? int'(r[30:28]) : 0);
    end
    close_out;
  end

  // Watchdog well beyond the expected run
  initial begin
    #(8 * 20000);
    n_errors++;
    close_out;
  end
endmodule // testbench

/* wse_core.sv */
// Word store execution: address forming, checks and memory write issue.
// Assumes decode supplies one request at a time and memory answers done/error.
//
// How it works
// [RQ1] Window store at nonzero ring: privilege fault
// [RQ2] Window address: base plus one-extended offset
// [RQ3] Window check ring: saved ring or zero
// [RQ4] Window offset spans minus 64 to minus 4
// [RQ5] Window store checks saved ring level
// [RQ6] Wide store: base plus 8-bit offset times four
// [RQ7] Every store writes all 32 source bits
// [RQ8] Translate when option present, else pass
// [RQ9] Translation or memory failure raises exception
// [RQ10] No unaligned option: low bits cleared
// [RQ11] Unaligned option: misaligned address faults
// [RQ12] Wide and narrow stores may hit IRAM
// [RQ13] Narrow store: 4-bit offset times four
// [RQ14] Release waits for earlier memory operations
// [RQ15] Release address: 8-bit offset times four
// [RQ16] Unconfigured store opcode is illegal
`timescale 1ns/10ps

module wse_core #(
  parameter bit HAS_MMU = 1'b1,
  parameter bit HAS_REGION_XLT = 1'b0,
  parameter bit HAS_UNALIGNED_EXC = 1'b1,
  parameter bit HAS_WINDOWED = 1'b1,
  parameter bit HAS_CODE_DENSITY = 1'b1,
  parameter bit HAS_MP_SYNC = 1'b1
) (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  // Request from issue
  input wire logic i_req_valid,
  input wire wse_pkg::wse_req_type i_req,
  input wire logic [1:0] i_current_privilege_ring,
  input wire logic [1:0] i_saved_ring_level,
  output logic o_req_ready,
  // Memory ordering state
  input wire logic i_mem_ops_pending,
  // Address translation unit
  output logic o_xlt_valid,
  output logic [31:0] o_xlt_vaddr,
  output logic [1:0] o_xlt_ring,
  input wire logic i_xlt_done,
  input wire logic [31:0] i_xlt_paddr,
  input wire logic i_xlt_fault,
  // Memory write port
  output logic o_mem_valid,
  output wse_pkg::wse_mem_type o_mem,
  input wire logic i_mem_done,
  input wire logic i_mem_error,
  // Completion
  output logic o_done,
  output logic o_exc,
  output logic [5:0] o_exc_cause,
  output logic [31:0] o_exc_vaddr,
  // Register port
  input wire logic [3:0] i_reg_addr,
  input wire logic [31:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [31:0] o_reg_rdata,
  output logic o_irq
);

  typedef enum {
    ST_IDLE,
    ST_DRAIN,
    ST_XLT,
    ST_MEM,
    ST_END
  } wse_state_type;

  typedef struct packed {
    wse_state_type state;
    logic [31:0] vaddr;
    logic [31:0] paddr;
    logic [31:0] data;
    logic [1:0] ring;
    logic iram_ok;
    logic done;
    logic exc;
    logic [5:0] cause;
    logic [wse_pkg::WSE_EV_COUNT-1:0] status;
    logic [wse_pkg::WSE_EV_COUNT-1:0] mask;
    logic rd_sel_reg;
    logic [31:0] rd_small;
  } wse_regs_type;

  wse_regs_type r;
  wse_regs_type next_r;

  // Offset forming shared by all variants
  function automatic logic [31:0] wse_offset(input wse_pkg::wse_op_type op, input logic [7:0] imm);
    logic [31:0] off;
    off = 32'h0000_0000;
    case (op)
      wse_pkg::WSE_OP_WINDOW: off = {{wse_pkg::WSE_WINDOW_ONES{1'b1}}, imm[3:0], 2'b00}; // RQ2 RQ4
      wse_pkg::WSE_OP_NARROW: off = {28'h0000000, imm[3:0]} << wse_pkg::WSE_SCALE_SHIFT; // RQ13
      default: off = {24'h000000, imm} << wse_pkg::WSE_SCALE_SHIFT; // RQ6 RQ15
    endcase
    return off;
  endfunction

  // Whether the opcode's option is configured
  function automatic logic wse_legal(input wse_pkg::wse_op_type op);
    logic ok;
    ok = 1'b0;
    case (op)
      wse_pkg::WSE_OP_WINDOW: ok = HAS_WINDOWED;
      wse_pkg::WSE_OP_WIDE: ok = 1'b1;
      wse_pkg::WSE_OP_NARROW: ok = HAS_CODE_DENSITY;
      wse_pkg::WSE_OP_RELEASE: ok = HAS_MP_SYNC;
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction

  localparam bit XLT_ON = HAS_MMU || HAS_REGION_XLT;

  logic [31:0] bank_rdata;
  logic bank_wr;
  logic [31:0] form_vaddr;
  logic misaligned;

  assign form_vaddr = i_req.base + wse_offset(i_req.op, i_req.imm);
  assign misaligned = (form_vaddr[1:0] != 2'b00);
  assign bank_wr = r.exc; // Faulting address is written into the bank while the exception pulse stands

  // Next state
  always_comb begin
    next_r = r;
    next_r.done = 1'b0;
    next_r.exc = 1'b0;
    case (r.state)
      ST_IDLE: begin
        if (i_req_valid && i_req.op != wse_pkg::WSE_OP_NONE) begin
          next_r.vaddr = form_vaddr;
          next_r.data = i_req.data; // RQ7
          next_r.iram_ok = (i_req.op == wse_pkg::WSE_OP_WIDE) || (i_req.op == wse_pkg::WSE_OP_NARROW); // RQ12
          next_r.ring = i_current_privilege_ring;
          if (i_req.op == wse_pkg::WSE_OP_WINDOW) begin
            next_r.ring = HAS_MMU ? i_saved_ring_level : wse_pkg::WSE_RING_ZERO; // RQ3 RQ5
          end
          if (!wse_legal(i_req.op)) begin
            next_r.cause = wse_pkg::WSE_CAUSE_ILLEGAL; // RQ16
            next_r.state = ST_END;
            next_r.exc = 1'b1;
          end else if (i_req.op == wse_pkg::WSE_OP_WINDOW && i_current_privilege_ring != wse_pkg::WSE_RING_ZERO) begin
            next_r.cause = wse_pkg::WSE_CAUSE_PRIV; // RQ1
            next_r.state = ST_END;
            next_r.exc = 1'b1;
          end else if (HAS_UNALIGNED_EXC && misaligned) begin
            next_r.cause = wse_pkg::WSE_CAUSE_UNALIGNED; // RQ11
            next_r.state = ST_END;
            next_r.exc = 1'b1;
          end else if (i_req.op == wse_pkg::WSE_OP_RELEASE) begin
            next_r.state = ST_DRAIN; // RQ14
          end else begin
            next_r.state = XLT_ON ? ST_XLT : ST_MEM;
          end
          if (!XLT_ON) begin
            next_r.paddr = {form_vaddr[31:2], 2'b00}; // RQ8 RQ10
          end
        end
      end
      ST_DRAIN: begin
        if (!i_mem_ops_pending) begin
          next_r.state = XLT_ON ? ST_XLT : ST_MEM; // RQ14
        end
      end
      ST_XLT: begin
        if (i_xlt_done) begin
          if (i_xlt_fault) begin
            next_r.cause = wse_pkg::WSE_CAUSE_STORE_PROHIBITED; // RQ9
            next_r.exc = 1'b1;
            next_r.state = ST_END;
          end else begin
            next_r.paddr = {i_xlt_paddr[31:2], 2'b00}; // RQ8 RQ10
            next_r.state = ST_MEM;
          end
        end
      end
      ST_MEM: begin
        if (i_mem_done) begin
          if (i_mem_error) begin
            next_r.cause = wse_pkg::WSE_CAUSE_STORE_ERROR; // RQ9
            next_r.exc = 1'b1;
          end else begin
            next_r.cause = wse_pkg::WSE_CAUSE_NONE;
          end
          next_r.done = 1'b1;
          next_r.state = ST_END;
        end
      end
      ST_END: begin
        next_r.state = ST_IDLE;
      end
      default: next_r.state = ST_IDLE;
    endcase
    // Completion pulse doubles as exception pulse on early faults
    if (next_r.exc) begin
      next_r.done = 1'b1;
    end
    // Sticky events; set wins over a write-one clear in the same cycle
    if (i_reg_wr && i_reg_addr == wse_pkg::WSE_REG_STATUS) begin
      next_r.status = r.status & ~i_reg_wdata[wse_pkg::WSE_EV_COUNT-1:0];
    end
    if (i_reg_wr && i_reg_addr == wse_pkg::WSE_REG_MASK) begin
      next_r.mask = i_reg_wdata[wse_pkg::WSE_EV_COUNT-1:0];
    end
    if (next_r.done) begin
      next_r.status[wse_pkg::WSE_EV_DONE] = 1'b1;
    end
    if (next_r.exc) begin
      next_r.status[wse_pkg::WSE_EV_EXC] = 1'b1;
    end
    // Registered read of the small control words
    next_r.rd_sel_reg = i_reg_rd && (i_reg_addr == wse_pkg::WSE_REG_LAST_ADDR);
    case (i_reg_addr)
      wse_pkg::WSE_REG_STATUS: next_r.rd_small = {30'h0, r.status};
      wse_pkg::WSE_REG_MASK: next_r.rd_small = {30'h0, r.mask};
      wse_pkg::WSE_REG_LAST_CAUSE: next_r.rd_small = {26'h0, r.cause};
      default: next_r.rd_small = 32'h0000_0000;
    endcase
    if (!i_reg_rd) begin
      next_r.rd_small = 32'h0000_0000;
    end
  end

  // State register
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      r <= '{state: ST_IDLE, default: '0};
    end else begin
      r <= next_r;
    end
  end

  // Last faulting address kept in the word bank; read path is registered there
  wse_reg_word #(
    .WORDS(4)
  ) u_bank (
    .i_clk_sys(i_clk_sys),
    .i_reset_n(i_reset_n),
    .i_wr(bank_wr),
    .i_wr_idx(2'h3),
    .i_wr_data(r.vaddr),
    .i_rd_idx(i_reg_addr[3:2]),
    .o_rd_data(bank_rdata)
  );

  // Outputs
  assign o_req_ready = (r.state == ST_IDLE);
  assign o_xlt_valid = (r.state == ST_XLT);
  assign o_xlt_vaddr = r.vaddr;
  assign o_xlt_ring = r.ring; // RQ5
  assign o_mem_valid = (r.state == ST_MEM);
  assign o_mem.paddr = r.paddr;
  assign o_mem.data = r.data; // RQ7
  assign o_mem.ring = r.ring;
  assign o_mem.to_iram_ok = r.iram_ok; // RQ12
  assign o_done = r.done;
  assign o_exc = r.exc;
  assign o_exc_cause = r.cause;
  assign o_exc_vaddr = r.vaddr;
  assign o_reg_rdata = r.rd_sel_reg ? bank_rdata : r.rd_small;
  assign o_irq = |(r.status & r.mask);

  // Checks
  a_window_priv: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    (r.state == ST_IDLE && i_req_valid && i_req.op == wse_pkg::WSE_OP_WINDOW && HAS_WINDOWED
     && i_current_privilege_ring != 2'h0) |=> (o_exc && o_exc_cause == wse_pkg::WSE_CAUSE_PRIV)) // RQ1
    else $error("window store at nonzero ring not faulted");
  a_release_wait: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    (r.state == ST_DRAIN && i_mem_ops_pending) |=> !o_mem_valid) // RQ14
    else $error("release store issued before drain");
  a_mem_aligned: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    o_mem_valid |-> o_mem.paddr[1:0] == 2'b00) // RQ10
    else $error("memory write address not word aligned");
  a_xlt_fault: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    (o_xlt_valid && i_xlt_done && i_xlt_fault) |=> (o_exc && !o_mem_valid)) // RQ9
    else $error("translation fault not raised");
  a_mem_error: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    (o_mem_valid && i_mem_done && i_mem_error) |=> o_exc) // RQ9
    else $error("memory error not raised");
  a_window_addr: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    (o_req_ready && i_req_valid && i_req.op == wse_pkg::WSE_OP_WINDOW)
    |=> o_xlt_vaddr == $past(i_req.base) + {26'h3FFFFFF, $past(i_req.imm[3:0]), 2'b00}) // RQ2
    else $error("window address wrong");
  a_narrow_addr: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    (o_req_ready && i_req_valid && i_req.op == wse_pkg::WSE_OP_NARROW)
    |=> o_xlt_vaddr == $past(i_req.base) + {26'h0, $past(i_req.imm[3:0]), 2'b00}) // RQ13
    else $error("narrow address wrong");
  a_wide_addr: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    (o_req_ready && i_req_valid && i_req.op == wse_pkg::WSE_OP_WIDE)
    |=> o_xlt_vaddr == $past(i_req.base) + {22'h0, $past(i_req.imm), 2'b00}) // RQ6
    else $error("wide address wrong");
  a_window_ring: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    (o_req_ready && i_req_valid && i_req.op == wse_pkg::WSE_OP_WINDOW)
    |=> o_xlt_ring == (HAS_MMU ? $past(i_saved_ring_level) : 2'h0)) // RQ3
    else $error("window ring wrong");
  a_irq_level: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    $rose(o_irq) |-> (o_done || $past(i_reg_wr && i_reg_addr == wse_pkg::WSE_REG_MASK)))
    else $error("interrupt raised without an event or a mask write");

endmodule // wse_core

/* wse_mem_model.sv */
// Partner model: translation unit and memory write port facing the store block.
// Assumes one clock; wait states and faults are commanded by the bench.
`timescale 1ns/10ps

module wse_mem_model #(
  parameter logic [31:0] XLT_OFS = 32'h1000_0000
) (
  // Clock and bench commands
  input wire logic i_clk_sys,
  input wire logic [1:0] i_delay,
  input wire logic i_fault_xlt,
  input wire logic i_fault_mem,
  // Translation side
  input wire logic i_xlt_valid,
  input wire logic [31:0] i_xlt_vaddr,
  output logic o_xlt_done = 1'b0,
  output logic [31:0] o_xlt_paddr = 32'h0,
  output logic o_xlt_fault = 1'b0,
  // Memory side
  input wire logic i_mem_valid,
  output logic o_mem_done = 1'b0,
  output logic o_mem_error = 1'b0
);
  logic [1:0] xcnt = 2'h0;
  logic [1:0] mcnt = 2'h0;

  // Answer after i_delay waits; a pulse is never repeated because no count runs while it stands
  always @(posedge i_clk_sys) begin
    o_xlt_done <= 1'b0;
    o_xlt_fault <= 1'b0;
    o_mem_done <= 1'b0;
    o_mem_error <= 1'b0;
    o_xlt_paddr <= ~o_xlt_paddr; // Stale address never looks valid
    if (i_xlt_valid && !o_xlt_done) begin
      xcnt <= xcnt + 2'h1;
      if (xcnt == i_delay) begin
        xcnt <= 2'h0;
        o_xlt_done <= 1'b1;
        o_xlt_fault <= i_fault_xlt;
        o_xlt_paddr <= i_xlt_vaddr + XLT_OFS;
      end
    end
    if (i_mem_valid && !o_mem_done) begin
      mcnt <= mcnt + 2'h1;
      if (mcnt == i_delay) begin
        mcnt <= 2'h0;
        o_mem_done <= 1'b1;
        o_mem_error <= i_fault_mem;
      end
    end
  end
endmodule // wse_mem_model

/* wse_pkg.sv */
// Package for the word store execution block: opcodes, causes, carriers.
// Assumes a single core clock domain and a decoded store request from issue.
package wse_pkg;

  // Store opcode selector supplied by decode
  typedef enum logic [2:0] {
    WSE_OP_NONE,
    WSE_OP_WINDOW,
    WSE_OP_WIDE,
    WSE_OP_NARROW,
    WSE_OP_RELEASE
  } wse_op_type;

  // Exception causes reported by the block
  localparam logic [5:0] WSE_CAUSE_NONE = 6'h00;
  localparam logic [5:0] WSE_CAUSE_ILLEGAL = 6'h00;
  localparam logic [5:0] WSE_CAUSE_PRIV = 6'h08;
  localparam logic [5:0] WSE_CAUSE_UNALIGNED = 6'h09;
  localparam logic [5:0] WSE_CAUSE_STORE_PROHIBITED = 6'h1D;
  localparam logic [5:0] WSE_CAUSE_STORE_ERROR = 6'h03;

  // Offset field layout
  localparam int WSE_SCALE_SHIFT = 2;
  localparam int WSE_WINDOW_ONES = 26;
  localparam int WSE_WIDE_BITS = 8;
  localparam int WSE_NARROW_BITS = 4;
  localparam logic [1:0] WSE_RING_ZERO = 2'h0;
  localparam logic [1:0] WSE_ALIGN_MASK = 2'h3;

  // Interrupt status bit positions
  localparam int WSE_EV_DONE = 0;
  localparam int WSE_EV_EXC = 1;
  localparam int WSE_EV_COUNT = 2;

  // Register offsets of the small control block
  localparam logic [3:0] WSE_REG_STATUS = 4'h0;
  localparam logic [3:0] WSE_REG_MASK = 4'h4;
  localparam logic [3:0] WSE_REG_LAST_CAUSE = 4'h8;
  localparam logic [3:0] WSE_REG_LAST_ADDR = 4'hC;

  // Store request from issue
  typedef struct packed {
    wse_op_type op;
    logic [31:0] base;
    logic [31:0] data;
    logic [7:0] imm;
  } wse_req_type;

  // Translated request toward the memory system
  typedef struct packed {
    logic [31:0] paddr;
    logic [31:0] data;
    logic [1:0] ring;
    logic to_iram_ok;
  } wse_mem_type;

endpackage : wse_pkg

/* wse_reg_word.sv */
// Small register bank; of the block's software visible words it holds only the last faulting address.
// Assumes one clock; read data come out of a register one cycle after the strobe.
`timescale 1ns/10ps

module wse_reg_word #(
  parameter int WORDS = 4
) (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  // Write side
  input wire logic i_wr,
  input wire logic [1:0] i_wr_idx,
  input wire logic [31:0] i_wr_data,
  // Read side
  input wire logic [1:0] i_rd_idx,
  output logic [31:0] o_rd_data
);

  // The index ports are two bits wide, so only four words can be served
  if (WORDS != 4) begin : g_words_check
    $error("wse_reg_word serves exactly four words");
  end

  logic [WORDS-1:0][31:0] mem;

  // Storage and registered read
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      mem <= '0;
      o_rd_data <= 32'h0000_0000;
    end else begin
      if (i_wr) begin
        mem[i_wr_idx] <= i_wr_data;
      end
      o_rd_data <= mem[i_rd_idx];
    end
  end

endmodule // wse_reg_word
